// >>> rtl/iscr_pkg.sv
// package of offsets, field positions and reset values for the config bank
package iscr_pkg;
	// byte addresses of the register set
	localparam logic [7:0] ADDR_UNIT_KIND        = 8'h00;
	localparam logic [7:0] ADDR_FW_MINOR         = 8'h01;
	localparam logic [7:0] ADDR_FW_MAJOR         = 8'h02;
	localparam logic [7:0] ADDR_NV_BLOCKS        = 8'h03;
	localparam logic [7:0] ADDR_SERIAL_LOW       = 8'h04;
	localparam logic [7:0] ADDR_SERIAL_MID       = 8'h05;
	localparam logic [7:0] ADDR_SERIAL_HIGH      = 8'h06;
	localparam logic [7:0] ADDR_VARIANT          = 8'h07;
	localparam logic [7:0] ADDR_UNIT_ADDRESS     = 8'h08;
	localparam logic [7:0] ADDR_FRAME_LOW        = 8'h0a;
	localparam logic [7:0] ADDR_FRAME_HIGH       = 8'h0b;
	localparam logic [7:0] ADDR_LETTER_FIRST     = 8'h0c;
	localparam logic [7:0] ADDR_LETTER_SECOND    = 8'h0d;
	localparam logic [7:0] ADDR_LINE_DIV         = 8'h0e;
	localparam logic [7:0] ADDR_OUT_DIV          = 8'h0f;
	localparam logic [7:0] ADDR_FORMAT           = 8'h10;
	localparam logic [7:0] ADDR_USER_CFG         = 8'h11;
	localparam logic [7:0] ADDR_OP_STATE         = 8'h12;
	localparam logic [7:0] ADDR_WARN             = 8'h17;
	// reset values
	localparam logic [7:0] RST_NV_BLOCKS         = 8'h10;
	localparam logic [2:0] RST_UNIT_ADDRESS      = 3'h0;
	localparam logic [7:0] RST_LINE_DIV          = 8'h08;
	localparam logic [7:0] RST_OUT_DIV           = 8'h05;
	localparam logic [7:0] RST_FORMAT            = 8'h03;
	localparam logic [2:0] RST_USER_CFG          = 3'h0;
	// supported packet formats
	localparam logic [7:0] FORMAT_COMPACT        = 8'h03;
	localparam logic [7:0] FORMAT_WITH_MAG       = 8'h04;
	// field positions
	localparam int UNIT_ADDR_MSB                 = 2;
	localparam int CFG_ALIGN_BIT                 = 2;
	localparam int CFG_SYNC_BIT                  = 1;
	localparam int CFG_BOOT_STREAM_BIT           = 0;
	localparam int OP_SYNC_LOCKED_BIT            = 3;
	localparam int OP_STREAMING_BIT              = 2;
	// start byte upper nibble, unit address below it
	localparam logic [3:0] START_NIBBLE          = 4'ha;
	// timing: 1 ms base tick for the output rate, at 250 MHz
	localparam int REF_CLK_MHZ                   = 250;
	localparam int BASE_TICK_US                  = 1000;
	localparam int BASE_TICK_CYCLES = BASE_TICK_US * REF_CLK_MHZ;
	// records per frame, and bits of the snapshot stream
	localparam int RECORDS_PER_FRAME             = 256;
	localparam int SNAPSHOT_BITS                 = 256;
endpackage

// >>> rtl/iscr_rate_divider.sv
// divider that pulses once every div ticks of an enable
`timescale 1ns/1ns
module iscr_rate_divider #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// tick in, divisor, pulse out
	input  wire logic         tick,
	input  wire logic [W-1:0] div,
	output logic              pulse
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         pulse_q;
	logic         pulse_d;

	// a divisor of zero is treated as one so the output never stalls
	always_comb begin
		cnt_d   = cnt_q;
		pulse_d = 1'b0;
		if (tick) begin
			if (cnt_q + W'(1) >= div) begin
				cnt_d   = '0;
				pulse_d = 1'b1;
			end else begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_q   <= '0;
			pulse_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign pulse = pulse_q;
endmodule

// >>> rtl/iscr_config_regs.sv
// lower configuration register bank with output rate and snapshot logic
//
// Overview of operation
// - fixed read-only unit kind code at zero
// - nonvolatile size in 64-byte blocks, 16
// - serial: 24-bit value plus two letters
// - read-only product variant code at 0x07
// - 3-bit writable unit address, upper bits reserved
// - 16-bit frame counter, per 256 records, wraps
// - line rate divisor byte, default 8
// - records at 1000 over output divisor per second
// - packet format select, 3 or 4, default 3
// - config bits: alignment, sync, boot streaming
// - status: sync locked bit 3, streaming bit 2
// - runtime warning flags, cleared at reset
// - start byte carries unit address, fixed nibble
// - one snapshot bit per packet over 256 bits
`timescale 1ns/1ns
module iscr_config_regs
	import iscr_pkg::*;
#(
	parameter logic [7:0] UNIT_KIND_CODE = 8'h5a,   // arbitrary value
	parameter logic [7:0] FW_MINOR       = 8'h01,
	parameter logic [7:0] FW_MAJOR       = 8'h01,
	parameter logic [23:0] SERIAL_VALUE  = 24'h000001,
	parameter logic [7:0] LETTER_FIRST   = 8'h41,
	parameter logic [7:0] LETTER_SECOND  = 8'h41,
	parameter logic [7:0] VARIANT_CODE   = 8'h00,
	parameter int         TICK_CYCLES    = BASE_TICK_CYCLES
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// byte register port from the command parser
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	output logic            reg_rvalid,
	// streaming control and sensor state
	input  wire logic       stream_on,
	input  wire logic       sync_pin,
	input  wire logic [7:0] warn_in,
	// configuration outputs to the rest of the unit
	output logic [7:0]      line_rate_divisor,
	output logic [7:0]      output_format_select,
	output logic            apply_alignment_matrix,
	output logic            ext_sync_enable,
	output logic            boot_streaming,
	// per-record outputs
	output logic            record_strobe,
	output logic [7:0]      start_byte,
	output logic            snapshot_bit
);
	logic [2:0]  addr_q, addr_d;
	logic [7:0]  line_q, line_d;
	logic [7:0]  odiv_q, odiv_d;
	logic [7:0]  fmt_q, fmt_d;
	logic [2:0]  cfg_q, cfg_d;
	logic [7:0]  warn_q, warn_d;
	logic [15:0] frame_q, frame_d;
	logic [7:0]  rec_q, rec_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic [7:0]  start_q, start_d;
	logic        snap_q, snap_d;
	logic        strb_q, strb_d;
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick_q, tick_d;
	logic        sync_m_q, sync_s_q;
	logic        sync_prev_q;
	logic [23:0] sync_age_q, sync_age_d;
	logic        record_pulse;
	logic [7:0]  snap_byte;
	logic [7:0]  op_state;
	logic        locked;

	// pin crossing for the sync input
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync_m_q    <= 1'b0;
			sync_s_q    <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			sync_m_q    <= sync_pin;
			sync_s_q    <= sync_m_q;
			sync_prev_q <= sync_s_q;
		end
	end

	// lock held while edges keep arriving; lost after 2^24 - 1 cycles
	// of silence (about 67 ms at 250 MHz), so a slow sync source still counts
	always_comb begin
		sync_age_d = sync_age_q;
		if (!cfg_q[CFG_SYNC_BIT]) begin
			sync_age_d = '1;
		end else if (sync_s_q && !sync_prev_q) begin
			sync_age_d = '0;
		end else if (sync_age_q != '1) begin
			sync_age_d = sync_age_q + 24'h000001;
		end
	end
	assign locked = cfg_q[CFG_SYNC_BIT] && (sync_age_q != '1);

	// 1 ms base tick feeding the output rate divider
	// free running: the first record may come up to odiv_q ticks after enable
	always_comb begin
		tick_d     = 1'b0;
		tick_cnt_d = tick_cnt_q + 32'h1;
		if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
		end
	end

	iscr_rate_divider #(.W(8)) u_out_rate (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (tick_q && stream_on),
		.div     (odiv_q),
		.pulse   (record_pulse)
	);

	// snapshot byte for the current record index, first 32 bytes only
	always_comb begin
		snap_byte = 8'h00;
		case (rec_q[7:3])
			5'd0:  snap_byte = UNIT_KIND_CODE;
			5'd1:  snap_byte = FW_MINOR;
			5'd2:  snap_byte = FW_MAJOR;
			5'd3:  snap_byte = RST_NV_BLOCKS;
			5'd4:  snap_byte = SERIAL_VALUE[7:0];
			5'd5:  snap_byte = SERIAL_VALUE[15:8];
			5'd6:  snap_byte = SERIAL_VALUE[23:16];
			5'd7:  snap_byte = VARIANT_CODE;
			5'd8:  snap_byte = {5'h00, addr_q};
			5'd10: snap_byte = frame_q[7:0];
			5'd11: snap_byte = frame_q[15:8];
			5'd12: snap_byte = LETTER_FIRST;
			5'd13: snap_byte = LETTER_SECOND;
			5'd14: snap_byte = line_q;
			5'd15: snap_byte = odiv_q;
			5'd16: snap_byte = fmt_q;
			5'd17: snap_byte = {5'h00, cfg_q};
			5'd18: snap_byte = op_state;
			5'd23: snap_byte = warn_q;
			default: snap_byte = 8'h00;
		endcase
	end

	// record counting, frame counter and per-record outputs
	// start byte and snapshot bit are latched with the strobe, so an address
	// write lands on the next record, never half way through one
	always_comb begin
		rec_d   = rec_q;
		frame_d = frame_q;
		start_d = start_q;
		snap_d  = snap_q;
		strb_d  = record_pulse;
		if (record_pulse) begin
			start_d = {START_NIBBLE, 1'b0, addr_q};
			snap_d  = snap_byte[rec_q[2:0]];
			rec_d   = rec_q + 8'h01;
			if (rec_q == 8'(RECORDS_PER_FRAME - 1)) begin
				frame_d = frame_q + 16'h0001;
			end
		end
	end

	// status byte built from live state
	assign op_state = {4'h0, locked, stream_on, 2'b00};

	// host writes; only writable fields of writable registers change
	always_comb begin
		addr_d = addr_q;
		line_d = line_q;
		odiv_d = odiv_q;
		fmt_d  = fmt_q;
		cfg_d  = cfg_q;
		if (reg_wr) begin
			if (reg_addr == ADDR_UNIT_ADDRESS) begin
				addr_d = reg_wdata[UNIT_ADDR_MSB:0];
			end else if (reg_addr == ADDR_LINE_DIV) begin
				line_d = reg_wdata;
			end else if (reg_addr == ADDR_OUT_DIV) begin
				odiv_d = reg_wdata;
			end else if (reg_addr == ADDR_FORMAT) begin
				// unsupported codes are dropped so the stream keeps a known format
				if (reg_wdata == FORMAT_COMPACT ||
				    reg_wdata == FORMAT_WITH_MAG) begin
					fmt_d = reg_wdata;
				end
			end else if (reg_addr == ADDR_USER_CFG) begin
				cfg_d = reg_wdata[2:0];
			end
		end
		// other addresses are read-only or reserved: dropped
	end

	// warning flags follow the sensor side live
	assign warn_d = warn_in;

	// read decode; reserved and unmapped addresses return zero
	// frame counter bytes are not latched as a pair, so a host reading them
	// across a frame step may see a torn value
	always_comb begin
		rvalid_d = reg_rd;
		rdata_d  = 8'h00;
		if (reg_rd) begin
			if (reg_addr == ADDR_UNIT_KIND) begin
				rdata_d = UNIT_KIND_CODE;
			end else if (reg_addr == ADDR_FW_MINOR) begin
				rdata_d = FW_MINOR;
			end else if (reg_addr == ADDR_FW_MAJOR) begin
				rdata_d = FW_MAJOR;
			end else if (reg_addr == ADDR_NV_BLOCKS) begin
				rdata_d = RST_NV_BLOCKS;
			end else if (reg_addr == ADDR_SERIAL_LOW) begin
				rdata_d = SERIAL_VALUE[7:0];
			end else if (reg_addr == ADDR_SERIAL_MID) begin
				rdata_d = SERIAL_VALUE[15:8];
			end else if (reg_addr == ADDR_SERIAL_HIGH) begin
				rdata_d = SERIAL_VALUE[23:16];
			end else if (reg_addr == ADDR_VARIANT) begin
				rdata_d = VARIANT_CODE;
			end else if (reg_addr == ADDR_UNIT_ADDRESS) begin
				rdata_d = {5'h00, addr_q};
			end else if (reg_addr == ADDR_FRAME_LOW) begin
				rdata_d = frame_q[7:0];
			end else if (reg_addr == ADDR_FRAME_HIGH) begin
				rdata_d = frame_q[15:8];
			end else if (reg_addr == ADDR_LETTER_FIRST) begin
				rdata_d = LETTER_FIRST;
			end else if (reg_addr == ADDR_LETTER_SECOND) begin
				rdata_d = LETTER_SECOND;
			end else if (reg_addr == ADDR_LINE_DIV) begin
				rdata_d = line_q;
			end else if (reg_addr == ADDR_OUT_DIV) begin
				rdata_d = odiv_q;
			end else if (reg_addr == ADDR_FORMAT) begin
				rdata_d = fmt_q;
			end else if (reg_addr == ADDR_USER_CFG) begin
				rdata_d = {5'h00, cfg_q};
			end else if (reg_addr == ADDR_OP_STATE) begin
				rdata_d = op_state;
			end else if (reg_addr == ADDR_WARN) begin
				rdata_d = warn_q;
			end
		end
	end

	// all state registers except the sync pin crossing flops
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			addr_q     <= RST_UNIT_ADDRESS;
			line_q     <= RST_LINE_DIV;
			odiv_q     <= RST_OUT_DIV;
			fmt_q      <= RST_FORMAT;
			cfg_q      <= RST_USER_CFG;
			warn_q     <= 8'h00;
			frame_q    <= 16'h0000;
			rec_q      <= 8'h00;
			rdata_q    <= 8'h00;
			rvalid_q   <= 1'b0;
			start_q    <= 8'h00;
			snap_q     <= 1'b0;
			strb_q     <= 1'b0;
			tick_cnt_q <= 32'h0;
			tick_q     <= 1'b0;
			sync_age_q <= '1;
		end else begin
			addr_q     <= addr_d;
			line_q     <= line_d;
			odiv_q     <= odiv_d;
			fmt_q      <= fmt_d;
			cfg_q      <= cfg_d;
			warn_q     <= warn_d;
			frame_q    <= frame_d;
			rec_q      <= rec_d;
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
			start_q    <= start_d;
			snap_q     <= snap_d;
			strb_q     <= strb_d;
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
			sync_age_q <= sync_age_d;
		end
	end

	// outputs straight from flops
	assign reg_rdata              = rdata_q;
	assign reg_rvalid             = rvalid_q;
	assign line_rate_divisor      = line_q;
	assign output_format_select   = fmt_q;
	assign apply_alignment_matrix = cfg_q[CFG_ALIGN_BIT];
	assign ext_sync_enable        = cfg_q[CFG_SYNC_BIT];
	assign boot_streaming         = cfg_q[CFG_BOOT_STREAM_BIT];
	assign record_strobe          = strb_q;
	assign start_byte             = start_q;
	assign snapshot_bit           = snap_q;
endmodule

// >>> testbench/iscr_config_properties.sv
// port assertions for the lower config register bank
`timescale 1ns/1ns
module iscr_config_checker
	import iscr_pkg::*;
(
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       reset,
	// byte register port
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	// configuration and record outputs
	input wire logic [7:0] line_rate_divisor,
	input wire logic [7:0] output_format_select,
	input wire logic       apply_alignment_matrix,
	input wire logic       ext_sync_enable,
	input wire logic       boot_streaming,
	input wire logic       record_strobe,
	input wire logic [7:0] start_byte
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// read handshake: one answer per request, none without
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_no_stray: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without a read");
	a_idle_zero: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_block_count: assert property (reg_rd && reg_addr == ADDR_NV_BLOCKS
		|=> reg_rdata == 8'h10) else $error("block count wrong");
	// divisor follows its writes and nothing else
	a_line_div: assert property (reg_wr && reg_addr == ADDR_LINE_DIV
		|=> line_rate_divisor == $past(reg_wdata))
		else $error("line divisor not written");
	a_div_hold: assert property (!(reg_wr && reg_addr == ADDR_LINE_DIV)
		|=> $stable(line_rate_divisor)) else $error("line divisor moved");
	a_format_refuse: assert property (reg_wr && reg_addr == ADDR_FORMAT
		&& !(reg_wdata inside {8'h03, 8'h04})
		|=> $stable(output_format_select)) else $error("bad format taken");
	a_cfg_bits: assert property (reg_wr && reg_addr == ADDR_USER_CFG
		|=> {apply_alignment_matrix, ext_sync_enable, boot_streaming}
		== $past(reg_wdata[2:0])) else $error("config bits wrong");
	a_start_nibble: assert property (record_strobe
		|-> start_byte[7:4] == 4'ha) else $error("start byte nibble wrong");
endmodule
bind iscr_config_regs iscr_config_checker chk_u (
	.ref_clk                (ref_clk),
	.reset                  (reset),
	.reg_wr                 (reg_wr),
	.reg_rd                 (reg_rd),
	.reg_addr               (reg_addr),
	.reg_wdata              (reg_wdata),
	.reg_rdata              (reg_rdata),
	.reg_rvalid             (reg_rvalid),
	.line_rate_divisor      (line_rate_divisor),
	.output_format_select   (output_format_select),
	.apply_alignment_matrix (apply_alignment_matrix),
	.ext_sync_enable        (ext_sync_enable),
	.boot_streaming         (boot_streaming),
	.record_strobe          (record_strobe),
	.start_byte             (start_byte)
);

// >>> testbench/iscr_host_model.sv
// host model issuing byte register requests
`timescale 1ns/1ns
module iscr_host_model (
	// clock
	input wire logic       ref_clk,
	// request lines
	output logic           reg_wr,
	output logic           reg_rd,
	output logic [7:0]     reg_addr,
	output logic [7:0]     reg_wdata,
	// answer lines
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// released lines are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// read data is taken while the one-cycle answer stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		d = reg_rvalid ? reg_rdata : 8'hxx;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// >>> testbench/tb_inertial_sensor_config_registers.sv
// self-checking bench for the lower config register bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_inertial_sensor_config_registers;
	import iscr_pkg::*;
	localparam logic [7:0]  KIND    = 8'h3c; // arbitrary value
	localparam logic [7:0]  FW_MIN  = 8'h12;
	localparam logic [7:0]  FW_MAJ  = 8'h01;
	localparam logic [23:0] SER     = 24'h0a0b0c;
	localparam logic [7:0]  LET1    = 8'h51;
	localparam logic [7:0]  LET2    = 8'h52;
	localparam logic [7:0]  VARIANT = 8'h02;
	localparam int          TICKS   = 10;
	// bench signals
	logic         ref_clk, reset, stream_on, sync_pin, reg_wr, reg_rd;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, warn_in, start_byte;
	logic         reg_rvalid, record_strobe, snapshot_bit, boot_streaming;
	logic         apply_alignment_matrix, ext_sync_enable;
	logic [7:0]   line_rate_divisor, output_format_select;
	logic [255:0] snap;
	int           errors, compares;
	time          t0;
	logic [7:0]   map_a [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
		8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h20};
	logic [7:0]   map_e [22] = '{KIND, FW_MIN, FW_MAJ, 8'h10, SER[7:0],
		SER[15:8], SER[23:16], VARIANT, 8'h00, 8'h00, 8'h00, 8'h00, LET1,
		LET2, 8'h08, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	iscr_config_regs #(.UNIT_KIND_CODE(KIND), .FW_MINOR(FW_MIN),
		.FW_MAJOR(FW_MAJ), .SERIAL_VALUE(SER), .LETTER_FIRST(LET1),
		.LETTER_SECOND(LET2), .VARIANT_CODE(VARIANT), .TICK_CYCLES(TICKS))
		dut_u (
		.ref_clk                (ref_clk),
		.reset                  (reset),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_rdata              (reg_rdata),
		.reg_rvalid             (reg_rvalid),
		.stream_on              (stream_on),
		.sync_pin               (sync_pin),
		.warn_in                (warn_in),
		.line_rate_divisor      (line_rate_divisor),
		.output_format_select   (output_format_select),
		.apply_alignment_matrix (apply_alignment_matrix),
		.ext_sync_enable        (ext_sync_enable),
		.boot_streaming         (boot_streaming),
		.record_strobe          (record_strobe),
		.start_byte             (start_byte),
		.snapshot_bit           (snapshot_bit)
	);
	iscr_host_model host_u (
		.ref_clk    (ref_clk),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_rdata  (reg_rdata),
		.reg_rvalid (reg_rvalid)
	);
	// clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
	task automatic give_verdict();
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic get(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		`CHK("reg", e, d)
	endtask
	task automatic put_get(input logic [7:0] a, input logic [7:0] d, e);
		host_u.wr(a, d);
		get(a, e);
	endtask
	// a strobe is one cycle, so each call finds the next one
	task automatic wait_strobe();
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (record_strobe !== 1'b1 && n < 100);
		if (n == 100) errors++;
	endtask
	// main sequence
	initial begin
		{stream_on, sync_pin, warn_in, reset} = {10'h0, 1'b1};
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		for (int i = 0; i < 22; i++) begin
			get(map_a[i], map_e[i]);
		end
		$display("test reset map done");
		put_get(ADDR_UNIT_ADDRESS, 8'hfd, 8'h05);
		put_get(ADDR_UNIT_KIND, 8'hff, KIND);
		put_get(ADDR_FRAME_LOW, 8'h77, 8'h00);
		put_get(ADDR_LINE_DIV, 8'h21, 8'h21);
		put_get(ADDR_FORMAT, 8'h04, 8'h04);
		put_get(ADDR_FORMAT, 8'h07, 8'h04);
		put_get(ADDR_FORMAT, 8'h03, 8'h03);
		put_get(ADDR_USER_CFG, 8'hff, 8'h07);
		put_get(ADDR_OP_STATE, 8'hff, 8'h00);
		put_get(ADDR_OUT_DIV, 8'h01, 8'h01);
		`CHK("cfg", 3'h7, {apply_alignment_matrix, ext_sync_enable, boot_streaming})
		`CHK("lrd", 8'h21, line_rate_divisor)
		`CHK("fmt", 8'h03, output_format_select)
		warn_in = 8'ha5;
		get(ADDR_WARN, 8'ha5);
		warn_in = 8'h5a;
		get(ADDR_WARN, 8'h5a);
		$display("test writes done");
		stream_on = 1'b1;
		for (int r = 0; r < 256; r++) begin
			wait_strobe();
			snap[r] = snapshot_bit;
		end
		`CHK("start", 8'ha5, start_byte)
		get(ADDR_FRAME_LOW, 8'h01);
		for (int i = 0; i < 8; i++) begin
			`CHK("snap", map_e[i], snap[8*i +: 8])
		end
		put_get(ADDR_OUT_DIV, 8'h02, 8'h02);
		wait_strobe();
		t0 = $time;
		wait_strobe();
		`CHK("period", 80, int'($time - t0))
		$display("test stream done");
		get(ADDR_OP_STATE, 8'h04);
		sync_pin = 1'b1;
		repeat (3) @(negedge ref_clk);
		sync_pin = 1'b0;
		repeat (4) @(negedge ref_clk);
		get(ADDR_OP_STATE, 8'h0c);
		$display("test sync done");
		give_verdict();
	end
endmodule
